// ===== logic/iasc_consts.svh
`ifndef IASC_CONSTS_SVH
`define IASC_CONSTS_SVH

// Register byte addresses; multi-byte values keep their low byte first.
`define IASC_A_CFG      15'h0000
`define IASC_A_CLASS    15'h0003
`define IASC_A_PART_LO  15'h0004
`define IASC_A_PART_HI  15'h0005
`define IASC_A_MAKER_LO 15'h000C
`define IASC_A_MAKER_HI 15'h000D
`define IASC_A_USER     15'h0010
`define IASC_A_SYNC     15'h0029
`define IASC_A_POS0     15'h002C
`define IASC_A_POS1     15'h002D
`define IASC_A_POS2     15'h002E
`define IASC_A_STEP     15'h0001

// Field positions.
`define IASC_B_ASCEND   5
`define IASC_B_SDO_ONLY 4
`define IASC_B_HOLD     0

// Reset values.
`define IASC_RST_CFG    8'h30
`define IASC_RST_RSV    4'h0
`define IASC_RST_USER   8'h00
`define IASC_RST_SYNC   8'h00
`define IASC_RST_BYTE   8'h00

// Frame layout: a 16-bit command word, then data bytes.
`define IASC_CMD_LAST   5'h0F
`define IASC_BYTE_LAST  5'h07
`define IASC_CNT_ZERO   5'h00
`define IASC_CNT_STEP   5'h01

`endif

// ===== logic/iasc_pkg.sv
package iasc_pkg;

  // Serial frame phase.
  typedef enum logic {IASC_PH_CMD, IASC_PH_DATA} iasc_phase_t;

  // Sync control byte, laid out as the register.
  typedef struct packed {
    logic       rsv;
    logic       proc_en;
    logic       recv_en;
    logic       zoom;
    logic [3:0] sel;
  } iasc_sync_ctl_t;

  // Edge detector state.
  typedef struct packed {
    logic prev;
  } iasc_edge_t;

  // Whole register bank and serial engine state.
  typedef struct packed {
    iasc_phase_t    phase;
    logic [4:0]     cnt;
    logic [15:0]    sh;
    logic [7:0]     tx;
    logic           rw;
    logic [14:0]    addr;
    logic           sdo;
    logic           sdo_oe;
    logic [7:0]     cfg_a;
    logic [3:0]     dc_rsv;
    logic [7:0]     user;
    iasc_sync_ctl_t sync;
    logic           evt;
  } iasc_state_t;

endpackage

// ===== logic/iasc_edge.sv
`timescale 1ns/100ps
// Finds the rising and falling edges of a level sampled on i_clk.
module iasc_edge (
  input  wire logic i_clk,  // System clock.
  input  wire logic i_rst,  // Synchronous reset, active high.
  input  wire logic i_lvl,  // Level to watch.
  output logic      o_rise, // High for the cycle the level goes high.
  output logic      o_fall  // High for the cycle the level goes low.
);
  import iasc_pkg::*;

  iasc_edge_t s_q;  // Registered copy of the level.
  iasc_edge_t s_d;  // Next value.

  // The previous sample is all that the detector needs.
  always_comb begin
    s_d      = s_q;
    s_d.prev = i_lvl;
  end

  // Reset to low so a clock idling low makes no false edge at start-up.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rise = i_lvl & ~s_q.prev;
  assign o_fall = ~i_lvl & s_q.prev;
endmodule

// ===== logic/iasc_regs.sv
`timescale 1ns/100ps
`include "iasc_consts.svh"
module iasc_regs #(
  parameter logic [3:0]  P_CLASS = 4'hA,    // Arbitrary value.
  parameter logic [15:0] P_PART  = 16'h5A17, // Arbitrary value.
  parameter logic [15:0] P_MAKER = 16'h6C2E  // Arbitrary value.
) (
  input  wire logic                     i_clk,     // 25 MHz clock.
  input  wire logic                     i_rst,     // Sync reset, high.
  input  wire logic                     i_sclk,    // Serial clock.
  input  wire logic                     i_scs_n,   // Chip select, low.
  input  wire logic                     i_sdi,     // Serial data in.
  output logic                          o_sdo,     // Serial data out.
  output logic                          o_sdo_oe,  // High while driving.
  input  wire logic [23:0]              i_edge_pos, // Edge position.
  input  wire logic                     i_sync_evt, // Raw sync event.
  output logic                          o_sync_evt, // Accepted event.
  output iasc_pkg::iasc_sync_ctl_t      o_sync_ctl  // Sync control.
);
  import iasc_pkg::*;

  // Reset image; the control byte starts cleared.
  localparam iasc_state_t ST_RST = '{
    phase:  IASC_PH_CMD,
    cfg_a:  `IASC_RST_CFG,
    dc_rsv: `IASC_RST_RSV,
    user:   `IASC_RST_USER,
    sync:   `IASC_RST_SYNC,
    default: '0
  };

  iasc_state_t s_q;        // Registered state.
  iasc_state_t s_d;        // Next state.
  logic        sclk_rise;  // Serial clock rising edge.
  logic        sclk_fall;  // Serial clock falling edge.
  logic        cmd_done;   // Last command bit taken.
  logic        byte_done;  // Last bit of a data byte taken.
  logic [7:0]  wdata;      // Byte completed by this edge.
  logic [14:0] next_addr;  // Address for the following byte.
  logic [14:0] cmd_addr;   // Address carried in the command word.

  // Edge finder on the serial clock.
  iasc_edge u_sclk_edge (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_lvl  (i_sclk),
    .o_rise (sclk_rise),
    .o_fall (sclk_fall)
  );

  // Read view of one byte; unmapped addresses read zero.
  function automatic logic [7:0] rd_byte(input logic [14:0] a,
                                         input iasc_state_t s,
                                         input logic [23:0] pos);
    logic [7:0] r;
    r = `IASC_RST_BYTE;
    if (a == `IASC_A_CFG) begin
      r = s.cfg_a;
      r[`IASC_B_SDO_ONLY] = 1'b1;  // Reads as one: output pin only.
    end else if (a == `IASC_A_CLASS) begin
      r = {s.dc_rsv, P_CLASS};
    end else if (a == `IASC_A_PART_LO) begin
      r = P_PART[7:0];
    end else if (a == `IASC_A_PART_HI) begin
      r = P_PART[15:8];
    end else if (a == `IASC_A_MAKER_LO) begin
      r = P_MAKER[7:0];
    end else if (a == `IASC_A_MAKER_HI) begin
      r = P_MAKER[15:8];
    end else if (a == `IASC_A_USER) begin
      r = s.user;
    end else if (a == `IASC_A_SYNC) begin
      r = s.sync;
    end else if (a == `IASC_A_POS0) begin
      r = pos[7:0];
    end else if (a == `IASC_A_POS1) begin
      r = pos[15:8];
    end else if (a == `IASC_A_POS2) begin
      r = pos[23:16];
    end
    return r;
  endfunction

  // Frame decode terms used by the state update and the checks.
  assign cmd_done  = ~i_scs_n & sclk_rise & (s_q.phase == IASC_PH_CMD)
                     & (s_q.cnt == `IASC_CMD_LAST);
  assign byte_done = ~i_scs_n & sclk_rise & (s_q.phase == IASC_PH_DATA)
                     & (s_q.cnt == `IASC_BYTE_LAST);
  assign wdata     = {s_q.sh[6:0], i_sdi};
  assign cmd_addr  = {s_q.sh[13:0], i_sdi};

  // Streaming step. The hold bit wins over the direction bit so that a
  // calibration port can be read or written many bytes in a row.
  always_comb begin
    if (s_q.user[`IASC_B_HOLD]) begin
      next_addr = s_q.addr;
    end else if (s_q.cfg_a[`IASC_B_ASCEND]) begin
      next_addr = s_q.addr + `IASC_A_STEP;
    end else begin
      next_addr = s_q.addr - `IASC_A_STEP;
    end
  end

  // Serial engine and register writes.
  always_comb begin
    s_d = s_q;
    // Events pass only with both receiver and processor on; a processor
    // enabled ahead of its receiver would otherwise see noise.
    s_d.evt = i_sync_evt & s_q.sync.proc_en
              & s_q.sync.recv_en;
    if (i_scs_n) begin
      // Deselect ends any frame, even one cut short mid-byte.
      s_d.phase  = IASC_PH_CMD;
      s_d.cnt    = `IASC_CNT_ZERO;
      s_d.sdo_oe = 1'b0;
    end else if (sclk_fall) begin
      // Read data changes on the falling edge for the host to sample.
      if (s_q.phase == IASC_PH_DATA && s_q.rw) begin
        s_d.sdo    = s_q.tx[7];
        s_d.tx     = {s_q.tx[6:0], 1'b0};
        s_d.sdo_oe = 1'b1;
      end
    end else if (sclk_rise) begin
      s_d.sh  = {s_q.sh[14:0], i_sdi};
      s_d.cnt = s_q.cnt + `IASC_CNT_STEP;
      if (cmd_done) begin
        s_d.rw    = s_q.sh[14];
        s_d.addr  = cmd_addr;
        s_d.phase = IASC_PH_DATA;
        s_d.cnt   = `IASC_CNT_ZERO;
        s_d.tx    = rd_byte(cmd_addr, s_q, i_edge_pos);
      end else if (byte_done) begin
        if (!s_q.rw) begin
          // Identifier and position bytes ignore writes, but the class byte stores its reserved upper nibble.
          if (s_q.addr == `IASC_A_CFG) begin
            s_d.cfg_a = wdata;
          end else if (s_q.addr == `IASC_A_CLASS) begin
            s_d.dc_rsv = wdata[7:4];
          end else if (s_q.addr == `IASC_A_USER) begin
            s_d.user = wdata;
          end else if (s_q.addr == `IASC_A_SYNC) begin
            s_d.sync = wdata;
          end
        end
        s_d.addr = next_addr;
        s_d.cnt  = `IASC_CNT_ZERO;
        s_d.tx   = rd_byte(next_addr, s_q, i_edge_pos);
      end
    end
  end

  // One register holds everything.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register. Zoom and select go to the
  // windowing logic outside, which sizes its steps from them.
  assign o_sdo      = s_q.sdo;
  assign o_sdo_oe   = s_q.sdo_oe;
  assign o_sync_evt = s_q.evt;
  assign o_sync_ctl = s_q.sync;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Class nibble never changes, whatever was written.
  AST_CLASS_FIXED: assert property (
    rd_byte(`IASC_A_CLASS, s_q, i_edge_pos) == {s_q.dc_rsv, P_CLASS})
    else $error("class nibble lost its fixed code");

  // Part identifier reads its code in both bytes.
  AST_PART_FIXED: assert property (
    {rd_byte(`IASC_A_PART_HI, s_q, i_edge_pos),
     rd_byte(`IASC_A_PART_LO, s_q, i_edge_pos)} == P_PART)
    else $error("part identifier wrong");

  // Maker identifier reads its code in both bytes.
  AST_MAKER_FIXED: assert property (
    {rd_byte(`IASC_A_MAKER_HI, s_q, i_edge_pos),
     rd_byte(`IASC_A_MAKER_LO, s_q, i_edge_pos)} == P_MAKER)
    else $error("maker identifier wrong");

  // Ascending stream moves up by one.
  AST_STEP_UP: assert property (
    byte_done && !s_q.user[`IASC_B_HOLD] && s_q.cfg_a[`IASC_B_ASCEND]
    |=> s_q.addr == $past(s_q.addr) + `IASC_A_STEP)
    else $error("address did not increment");

  // Descending stream moves down by one.
  AST_STEP_DOWN: assert property (
    byte_done && !s_q.user[`IASC_B_HOLD] && !s_q.cfg_a[`IASC_B_ASCEND]
    |=> s_q.addr == $past(s_q.addr) - `IASC_A_STEP)
    else $error("address did not decrement");

  // Held address stays put for the two cycles after the byte.
  AST_HOLD: assert property (
    byte_done && s_q.user[`IASC_B_HOLD] && !i_scs_n
    |=> $stable(s_q.addr) [*2])
    else $error("address moved while held");

  // No accepted event while the processor is off.
  AST_EVT_GATE: assert property (
    !s_q.sync.proc_en ##1 !s_q.sync.proc_en |-> !o_sync_evt)
    else $error("event passed with processor off");

  // Event with both enables on appears one cycle later.
  AST_EVT_PASS: assert property (
    i_sync_evt && s_q.sync.proc_en && s_q.sync.recv_en |=> o_sync_evt)
    else $error("accepted event missing");

  // A written control byte reaches the outputs next cycle.
  AST_SYNC_WRITE: assert property (
    byte_done && !s_q.rw && s_q.addr == `IASC_A_SYNC
    |=> o_sync_ctl == $past(wdata))
    else $error("sync control write lost");

  // Reserved class bits store what was written.
  AST_RSV_STORE: assert property (
    byte_done && !s_q.rw && s_q.addr == `IASC_A_CLASS
    |=> s_q.dc_rsv == $past(wdata[7:4]))
    else $error("reserved class bits not stored");

  // Top position byte mirrors the status input.
  AST_POS_READ: assert property (
    rd_byte(`IASC_A_POS2, s_q, i_edge_pos) == i_edge_pos[23:16])
    else $error("edge position top byte wrong");

  // Control byte is clear right after reset.
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    $past(i_rst) |-> o_sync_ctl == `IASC_RST_SYNC)
    else $error("sync control not clear after reset");

  COV_READ: cover property (cmd_done && s_q.sh[14]);
  COV_STREAM: cover property (byte_done ##[1:300] byte_done);
  COV_EVT: cover property (o_sync_evt);
endmodule

// ===== sim/iasc_host.sv
`timescale 1ns/100ps
// Serial host that configures the register bank. It acts on the falling
// edge of i_clk, keeps sclk low and scs_n high between frames, and
// inverts sdi once as each frame ends, leaving it steady while idle.
module iasc_host (
  input  wire logic i_clk,   // System clock.
  input  wire logic i_sdo,   // Read data from the device.
  output logic      o_sclk,  // Serial clock, idle low.
  output logic      o_scs_n, // Chip select, active low.
  output logic      o_sdi    // Serial data to the device.
);
  // Four cycles per level gives the device margin over its two-cycle minimum.
  localparam int HALF = 4;

  // Idle levels from time zero.
  initial begin
    o_sclk  = 1'b0;
    o_scs_n = 1'b1;
    o_sdi   = 1'b0;
  end

  // One whole frame: command word, then n bytes, low byte at first address.
  task automatic frame(input logic rd, input logic [14:0] a, input int n,
                       input logic [31:0] wd, output logic [31:0] rdo);
    logic [15:0] cmd;
    int          k;
    int          j;
    cmd = {rd, a};
    rdo = 32'h0000_0000;
    @(negedge i_clk);
    o_scs_n = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      k = (i - 16) / 8;
      j = 7 - (i - 16) % 8;
      // Data changes only while sclk is low, MSB first.
      o_sdi = (i < 16) ? cmd[15-i] : wd[8*k+j];
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b1;
      // Read data is taken at the rising edge, as the host would.
      if (i >= 16) begin
        rdo[8*k+j] = i_sdo;
      end
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (HALF) @(negedge i_clk);
    o_scs_n = 1'b1;
    o_sdi   = ~o_sdi;
    repeat (2) @(negedge i_clk);
  endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/100ps
// Self-checking bench for the identification and sync control registers.
module tb;
  import iasc_pkg::*;
  localparam logic [3:0]  CLS   = 4'hA;     // Arbitrary value.
  localparam logic [15:0] PART  = 16'h5A17; // Arbitrary value.
  localparam logic [15:0] MAKER = 16'h6C2E; // Arbitrary value.
  localparam int          LIMIT = 60000;    // Run needs well under this.

  logic           i_clk;       // System clock.
  logic           i_rst;       // Synchronous reset.
  logic           sclk;        // Serial clock.
  logic           scs_n;       // Chip select, active low.
  logic           sdi;         // Serial data in.
  logic           sdo;         // Serial data out.
  logic           sdo_oe;      // Serial output enable.
  logic [23:0]    i_edge_pos;  // Edge position status.
  logic           i_sync_evt;  // Raw sync event.
  logic           o_sync_evt;  // Accepted sync event.
  iasc_sync_ctl_t o_sync_ctl;  // Sync control register.
  integer         seed;        // Random seed.
  int             mismatches;  // Failed comparisons.
  int             checks_done; // All comparisons.
  int             cyc;         // Cycle counter for the hang guard.
  logic           exp_e;       // Expected accepted event.
  logic           live;        // Event check armed after reset.
  logic [31:0]    r;           // Read data.
  logic [7:0]     v;           // Random event draw, owned by the event loop.
  logic [7:0]     sv;          // Random sync control value for the main run.

  iasc_regs #(.P_CLASS(CLS), .P_PART(PART), .P_MAKER(MAKER)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_scs_n(scs_n),
    .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_edge_pos(i_edge_pos),
    .i_sync_evt(i_sync_evt), .o_sync_evt(o_sync_evt),
    .o_sync_ctl(o_sync_ctl));

  iasc_host host (.i_clk(i_clk), .i_sdo(sdo), .o_sclk(sclk),
                  .o_scs_n(scs_n), .o_sdi(sdi));

  // An event passes only with both receiver and processor enabled.
  function automatic logic evt_exp(input logic e, input iasc_sync_ctl_t c);
    return e & c.proc_en & c.recv_en;
  endfunction

  // Compare one value and report a mismatch at once.
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Print the counts and the verdict, then end the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [14:0] a, input int n,
                    input logic [31:0] d);
    logic [31:0] x;
    host.frame(1'b0, a, n, d, x);
  endtask

  task automatic rd(input logic [14:0] a, input int n,
                    output logic [31:0] d);
    host.frame(1'b1, a, n, 32'h0000_0000, d);
  endtask

  // Free-running 25 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Hang guard: a run that overstays counts as a failure.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  // Random events every cycle; the answer is due one cycle later.
  always @(negedge i_clk) begin
    if (live && !i_rst) begin
      check("sync_evt", {31'h0, exp_e}, {31'h0, o_sync_evt});
    end
    v          = 8'($random(seed));
    exp_e      = evt_exp(v[0], o_sync_ctl);
    live       = !i_rst;
    i_sync_evt <= v[0];
  end

  // Main sequence.
  initial begin
    seed       = 32'hDA94;
    i_rst      = 1'b1;
    i_sync_evt = 1'b0;
    i_edge_pos = 24'h00_0000;
    live       = 1'b0;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    rd(15'h0029, 1, r);
    check("sync_rst", 32'h0, r);
    check("sync_ctl_rst", 32'h0, o_sync_ctl);
    check("sdo_oe_idle", 32'h0, {31'h0, sdo_oe});
    rd(15'h0003, 3, r);
    check("ids", {8'h00, PART, 4'h0, CLS}, r);
    wr(15'h0003, 3, 32'h00A5_A5FF);
    rd(15'h0003, 3, r);
    check("ids_wr", {8'h00, PART, 4'hF, CLS}, r);
    rd(15'h000C, 2, r);
    check("maker", {16'h0, MAKER}, r);
    // Descending stream reads the high byte first.
    wr(15'h0000, 1, 32'h10);
    rd(15'h000D, 2, r);
    check("descend", {16'h0, MAKER[7:0], MAKER[15:8]}, r);
    wr(15'h0000, 1, 32'h30);
    // With the hold bit set every byte lands on the same register.
    wr(15'h0010, 1, 32'h01);
    wr(15'h0029, 4, 32'h1A6B_2507);
    check("hold_wr", 32'h1A, o_sync_ctl);
    rd(15'h0010, 2, r);
    check("hold_rd", 32'h0101, r);
    wr(15'h0010, 1, 32'h00);
    for (int i = 0; i < 6; i++) begin
      // The event loop redraws v every cycle, so the main run keeps its own.
      sv = (i == 0) ? 8'h7F : 8'($random(seed));
      if (sv[6]) begin
        sv[5] = 1'b1;
      end
      wr(15'h0029, 1, {24'h0, sv});
      check("sync_ctl", {24'h0, sv}, o_sync_ctl);
      rd(15'h0029, 1, r);
      check("sync_rd", {24'h0, sv}, r);
    end
    @(negedge i_clk);
    i_edge_pos = 24'($random(seed));
    rd(15'h002C, 3, r);
    check("edge_pos", {8'h00, i_edge_pos}, r);
    rd(15'h07F0, 1, r);
    check("unmapped", 32'h0, r);
    // Several valid windows in the position status: the host zooms in.
    wr(15'h0029, 1, 32'h30);
    check("sync_zoom", 32'h30, o_sync_ctl);
    wr(15'h0029, 1, 32'h60);
    check("sync_final", 32'h60, o_sync_ctl);
    report_and_stop();
  end
endmodule
